// ===== rcms_defs.svh
// offsets, field positions, reset values and counts for the clock monitor
`ifndef RCMS_DEFS_SVH
`define RCMS_DEFS_SVH
// apb byte addresses
`define RCMS_CTRL_ADDR      8'h00
`define RCMS_MON_A_ADDR     8'h04
`define RCMS_MON_B_ADDR     8'h08
`define RCMS_STATUS_ADDR    8'h0C
`define RCMS_FLAGS_ADDR     8'h10
`define RCMS_MASK_ADDR      8'h14
// ctrl fields
`define RCMS_CTRL_SEL_LO    0
`define RCMS_CTRL_SEL_HI    1
`define RCMS_CTRL_PRI_B     2
`define RCMS_CTRL_REVERT    3
`define RCMS_CTRL_GPIO_LA   4
`define RCMS_CTRL_GPIO_LB   5
`define RCMS_CTRL_GPIO_HO   6
`define RCMS_CTRL_W         7
`define RCMS_CTRL_RST       7'h00
// monitor target width and reset value
`define RCMS_MON_W          17
`define RCMS_MON_RST        17'h00100
// interrupt flags: los a change, los b change, holdover entry
`define RCMS_FLAG_W         3
`define RCMS_MASK_RST       3'h7
// rising edges needed to validate an input
`define RCMS_VAL_EDGES      4'h8
// monitor clock is the oscillator divided by this
`define RCMS_MON_DIV        8
`endif

// ===== rcms_pkg.sv
// types and shared helpers for the clock monitor
package rcms_pkg;
  // loop control states
  typedef enum logic [1:0] {
    RCMS_FREE_RUN,
    RCMS_LOCK,
    RCMS_HOLDOVER
  } rcms_state_e;
  // reference_select_field encodings
  typedef enum logic [1:0] {
    RCMS_SEL_AUTO,
    RCMS_SEL_MAN_A,
    RCMS_SEL_MAN_B,
    RCMS_SEL_PIN
  } rcms_sel_e;
  // count has reached the target (target zero behaves as one)
  function automatic logic rcms_expired(input logic [16:0] cnt,
                                        input logic [16:0] tgt);
    rcms_expired = ({1'b0, cnt} + 18'h00001) >= {1'b0, tgt};
  endfunction
  // highest priority valid input: {found, pick_b}
  function automatic logic [1:0] rcms_pick(input logic pri_b,
                                           input logic va,
                                           input logic vb);
    logic pv;
    logic ov;
    pv = pri_b ? vb : va;
    ov = pri_b ? va : vb;
    if (pv) rcms_pick = {1'b1, pri_b};
    else if (ov) rcms_pick = {1'b1, ~pri_b};
    else rcms_pick = 2'h0;
  endfunction
endpackage

// ===== rcms_los_mon.sv
// loss-of-signal monitor for one reference input
`timescale 1ns/10ps
`include "rcms_defs.svh"
module rcms_los_mon (
  input  wire logic        clk_in,      // monitor clock
  input  wire logic        rst_in,      // sync reset, high
  input  wire logic        ref_rise_in, // synced reference edge
  input  wire logic [16:0] target_in,   // programmed target
  output logic             soft_out,    // soft alarm
  output logic             los_out      // loss of signal
);
  logic [16:0] cnt_reg;  // monitor clock edge count
  logic [3:0]  val_reg;  // validation edge count
  logic        soft_reg; // soft alarm
  logic        los_reg;  // declared loss
  wire  expire   = rcms_pkg::rcms_expired(cnt_reg, target_in) & ~ref_rise_in;
  wire  val_done = los_reg & ref_rise_in & (val_reg == `RCMS_VAL_EDGES - 4'h1);

  always_ff @(posedge clk_in) begin
    if (rst_in || ref_rise_in || expire) cnt_reg <= 17'h00000;
    else cnt_reg <= cnt_reg + 17'h00001;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) soft_reg <= 1'b0;
    else if (expire) soft_reg <= 1'b1;
    else if (ref_rise_in && !los_reg) soft_reg <= 1'b0;
    else if (val_done) soft_reg <= 1'b0;
  end

  // second expiry declares loss, held until validated
  // reset to lost: an input must earn eight edges before use
  always_ff @(posedge clk_in) begin
    if (rst_in) los_reg <= 1'b1;
    else if (expire && soft_reg) los_reg <= 1'b1;
    else if (val_done) los_reg <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || !los_reg || expire || val_done) val_reg <= 4'h0;
    else if (ref_rise_in) val_reg <= val_reg + 4'h1;
  end

  assign soft_out = soft_reg;
  assign los_out  = los_reg;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_cnt_restart: assert property (ref_rise_in |=> cnt_reg == 17'h00000)
    else $error("count not restarted by reference edge");
  chk_los_second: assert property (soft_reg && expire |=> los_reg)
    else $error("second expiry did not declare loss");
  chk_soft_clear: assert property (soft_reg && !los_reg && ref_rise_in |=> !soft_reg)
    else $error("soft alarm not cleared by edge");
  chk_val_restart: assert property (los_reg && expire |=> los_reg && val_reg == 4'h0)
    else $error("validation not restarted on error");
  chk_val_eight: assert property (los_reg && val_done |=> !los_reg && !soft_reg)
    else $error("eight edges did not validate input");
  cov_los_seen: cover property (soft_reg && expire);
endmodule // rcms_los_mon

// ===== rcms_ref_select.sv
// reference monitoring, selection and loop state control with apb registers
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "rcms_defs.svh"
module rcms_ref_select (
  input  wire logic        clk_in,              // monitor clock, 100 mhz
  input  wire logic        srst_in,             // sync reset, high
  input  wire logic        master_reset_low_in, // master reset pin, low
  input  wire logic        ref_input_a_in,      // reference input a
  input  wire logic        ref_input_b_in,      // reference input b
  input  wire logic        clock_select_pin_in, // clock select pin
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb enable
  input  wire logic        pwrite,              // apb direction
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  output logic             lock_out,            // loop locked
  output logic             holdover_out,        // loop in holdover
  output logic             ref_b_active_out,    // input b selected
  output logic             track_freeze_out,    // freeze tracking
  output logic             los_a_gpio_out,      // routed los a
  output logic             los_b_gpio_out,      // routed los b
  output logic             hold_gpio_out,       // routed holdover alarm
  output logic             interrupt_request_pin_out,    // driven level
  output logic             interrupt_request_pin_oe_out  // drive enable
);
  // ---------------- reset and pin synchronisers
  logic       mrst_s1_reg;  // master reset, first stage
  logic       mrst_s2_reg;  // master reset, second stage
  logic [2:0] ra_sync_reg;  // input a sync + edge history
  logic [2:0] rb_sync_reg;  // input b sync + edge history
  logic [1:0] clock_select_pin_sync_reg; // select pin sync

  // pin reset passes two flops; reset to released
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mrst_s1_reg <= 1'b1;
      mrst_s2_reg <= 1'b1;
    end else begin
      mrst_s1_reg <= master_reset_low_in;
      mrst_s2_reg <= mrst_s1_reg;
    end
  end

  wire rst = srst_in | ~mrst_s2_reg;

  // two-flop sync, edge taken after stage two
  always_ff @(posedge clk_in) begin
    ra_sync_reg   <= {ra_sync_reg[1:0], ref_input_a_in};
    rb_sync_reg   <= {rb_sync_reg[1:0], ref_input_b_in};
    clock_select_pin_sync_reg <= {clock_select_pin_sync_reg[0], clock_select_pin_in};
  end

  // edge detect reads stages two and three only
  wire rise_a = ra_sync_reg[1] & ~ra_sync_reg[2];
  wire rise_b = rb_sync_reg[1] & ~rb_sync_reg[2];

  // ---------------- registers
  logic [`RCMS_CTRL_W-1:0] ctrl_reg;  // control
  logic [`RCMS_MON_W-1:0]  mon_a_reg; // monitor target a
  logic [`RCMS_MON_W-1:0]  mon_b_reg; // monitor target b
  logic [`RCMS_FLAG_W-1:0] flag_reg;  // sticky event flags
  logic [`RCMS_FLAG_W-1:0] mask_reg;  // 1 masks a flag
  logic [`RCMS_FLAG_W-1:0] flag_next; // flags after update

  // ---------------- monitors
  logic soft_a; // soft alarm a
  logic soft_b; // soft alarm b
  logic los_a;  // loss a
  logic los_b;  // loss b

  // one monitor per input on the monitor clock
  rcms_los_mon u_mon_a (
    .clk_in      (clk_in),
    .rst_in      (rst),
    .ref_rise_in (rise_a),
    .target_in   (mon_a_reg),
    .soft_out    (soft_a),
    .los_out     (los_a)
  );
  rcms_los_mon u_mon_b (
    .clk_in      (clk_in),
    .rst_in      (rst),
    .ref_rise_in (rise_b),
    .target_in   (mon_b_reg),
    .soft_out    (soft_b),
    .los_out     (los_b)
  );

  // ---------------- selection
  rcms_pkg::rcms_state_e state_reg;  // loop state
  rcms_pkg::rcms_state_e state_next; // next loop state
  logic sel_b_reg;   // active reference is b
  logic sel_b_next;  // next active reference
  logic los_a_d_reg; // previous loss a
  logic los_b_d_reg; // previous loss b

  wire [1:0] sel_mode = ctrl_reg[`RCMS_CTRL_SEL_HI:`RCMS_CTRL_SEL_LO];
  wire       pri_b    = ctrl_reg[`RCMS_CTRL_PRI_B];
  wire       revert   = ctrl_reg[`RCMS_CTRL_REVERT];
  wire       valid_a  = ~los_a;
  wire       valid_b  = ~los_b;
  wire       is_auto  = sel_mode == rcms_pkg::RCMS_SEL_AUTO;
  wire       cur_ok   = sel_b_reg ? valid_b : valid_a;
  // single priority bit ranks the inputs
  wire [1:0] best     = rcms_pkg::rcms_pick(pri_b, valid_a, valid_b);
  // pin mode: synced pin picks the input
  wire       man_b    = (sel_mode == rcms_pkg::RCMS_SEL_MAN_B) |
                        ((sel_mode == rcms_pkg::RCMS_SEL_PIN) & clock_select_pin_sync_reg[1]);

  // choose next active reference
  always_comb begin
    sel_b_next = sel_b_reg;
    if (!is_auto) begin
      // manual or pin mode: fixed by the select field or the synced select pin only
      sel_b_next = man_b;
    end else if (!cur_ok || state_reg == rcms_pkg::RCMS_FREE_RUN) begin
      // failure or power-up: best valid input
      if (best[1]) sel_b_next = best[0];
    end else if (revert && best[1] && best[0] != sel_b_reg) begin
      sel_b_next = best[0];
    end
  end

  wire next_ok = sel_b_next ? valid_b : valid_a;

  // loop state transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // wait in free-run, lock once validated
      rcms_pkg::RCMS_FREE_RUN: if (next_ok) state_next = rcms_pkg::RCMS_LOCK;
      rcms_pkg::RCMS_LOCK: if (!next_ok) state_next = rcms_pkg::RCMS_HOLDOVER;
      // back to lock once allowed input valid
      rcms_pkg::RCMS_HOLDOVER: if (next_ok) state_next = rcms_pkg::RCMS_LOCK;
      default: state_next = rcms_pkg::RCMS_FREE_RUN;
    endcase
  end

  // state register, switch without leaving lock
  always_ff @(posedge clk_in) begin
    if (rst) begin
      state_reg <= rcms_pkg::RCMS_FREE_RUN;
      sel_b_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_b_reg <= sel_b_next;
    end
  end

  // ---------------- events
  // holdover entry is its own alarm
  wire hold_enter = (state_next == rcms_pkg::RCMS_HOLDOVER) &
                    (state_reg != rcms_pkg::RCMS_HOLDOVER);
  // any change of loss status is an event
  wire [`RCMS_FLAG_W-1:0] flag_set = {hold_enter, los_b ^ los_b_d_reg,
                                      los_a ^ los_a_d_reg};

  // ---------------- apb
  wire setup    = psel & ~penable;
  wire wr_now   = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == `RCMS_CTRL_ADDR;
  wire hit_mona = paddr == `RCMS_MON_A_ADDR;
  wire hit_monb = paddr == `RCMS_MON_B_ADDR;
  wire hit_stat = paddr == `RCMS_STATUS_ADDR;
  wire hit_flag = paddr == `RCMS_FLAGS_ADDR;
  wire hit_mask = paddr == `RCMS_MASK_ADDR;
  wire mapped   = hit_ctrl | hit_mona | hit_monb | hit_stat | hit_flag | hit_mask;
  // status: state, active input, alarms
  wire [31:0] status_word = {24'h000000, state_reg == rcms_pkg::RCMS_HOLDOVER,
                             los_b, los_a, soft_b, soft_a, sel_b_reg, state_reg};
  wire [31:0] rd_word = hit_ctrl ? {25'h0, ctrl_reg} :
                        hit_mona ? {15'h0, mon_a_reg} :
                        hit_monb ? {15'h0, mon_b_reg} :
                        hit_stat ? status_word :
                        hit_flag ? {29'h0, flag_reg} :
                        hit_mask ? {29'h0, mask_reg} : 32'h00000000;
  wire [`RCMS_FLAG_W-1:0] flag_clr = (wr_now & hit_flag) ?
                                     pwdata[`RCMS_FLAG_W-1:0] : 3'h0;

  // answer in the cycle after setup, no wait states
  always_ff @(posedge clk_in) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? rd_word : 32'h00000000;
    end
  end

  // writable registers
  always_ff @(posedge clk_in) begin
    if (rst) begin
      ctrl_reg  <= `RCMS_CTRL_RST;
      mon_a_reg <= `RCMS_MON_RST;
      mon_b_reg <= `RCMS_MON_RST;
      mask_reg  <= `RCMS_MASK_RST;
    end else if (wr_now) begin
      if (hit_ctrl) ctrl_reg <= pwdata[`RCMS_CTRL_W-1:0];
      if (hit_mona) mon_a_reg <= pwdata[`RCMS_MON_W-1:0];
      if (hit_monb) mon_b_reg <= pwdata[`RCMS_MON_W-1:0];
      if (hit_mask) mask_reg <= pwdata[`RCMS_FLAG_W-1:0];
    end
  end

  // sticky flags: a set in the clear cycle wins
  assign flag_next = (flag_reg & ~flag_clr) | flag_set;

  // flag and history registers
  always_ff @(posedge clk_in) begin
    if (rst) begin
      flag_reg    <= 3'h0;
      // history matches the lost state the monitors reset to
      los_a_d_reg <= 1'b1;
      los_b_d_reg <= 1'b1;
    end else begin
      flag_reg    <= flag_next;
      los_a_d_reg <= los_a;
      los_b_d_reg <= los_b;
    end
  end

  // ---------------- registered outputs
  // status pins, freeze on active soft alarm
  always_ff @(posedge clk_in) begin
    if (rst) begin
      lock_out                     <= 1'b0;
      holdover_out                 <= 1'b0;
      ref_b_active_out             <= 1'b0;
      track_freeze_out             <= 1'b0;
      los_a_gpio_out               <= 1'b0;
      los_b_gpio_out               <= 1'b0;
      hold_gpio_out                <= 1'b0;
      interrupt_request_pin_out    <= 1'b0;
      interrupt_request_pin_oe_out <= 1'b0;
    end else begin
      lock_out         <= state_next == rcms_pkg::RCMS_LOCK;
      holdover_out     <= state_next == rcms_pkg::RCMS_HOLDOVER;
      ref_b_active_out <= sel_b_next;
      track_freeze_out <= sel_b_reg ? soft_b : soft_a;
      los_a_gpio_out   <= ctrl_reg[`RCMS_CTRL_GPIO_LA] & los_a;
      los_b_gpio_out   <= ctrl_reg[`RCMS_CTRL_GPIO_LB] & los_b;
      hold_gpio_out    <= ctrl_reg[`RCMS_CTRL_GPIO_HO] &
                          (state_next == rcms_pkg::RCMS_HOLDOVER);
      // open drain: only ever pulls low
      interrupt_request_pin_out    <= 1'b0;
      interrupt_request_pin_oe_out <= |(flag_next & ~mask_reg);
    end
  end

  // ---------------- checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst);

  chk_free_start: assert property ($fell(rst) |-> state_reg == rcms_pkg::RCMS_FREE_RUN)
    else $error("not in free-run after reset");
  chk_lock_valid: assert property (state_reg == rcms_pkg::RCMS_FREE_RUN && next_ok
                    |=> state_reg == rcms_pkg::RCMS_LOCK && lock_out)
    else $error("valid reference did not lock");
  chk_hold_entry: assert property (state_reg == rcms_pkg::RCMS_LOCK && los_a && los_b
                    |=> state_reg == rcms_pkg::RCMS_HOLDOVER)
    else $error("no holdover with all inputs lost");
  chk_auto_switch: assert property (is_auto && state_reg == rcms_pkg::RCMS_LOCK &&
                    !cur_ok && (sel_b_reg ? valid_a : valid_b)
                    |=> sel_b_reg != $past(sel_b_reg) && state_reg == rcms_pkg::RCMS_LOCK)
    else $error("auto failover did not switch");
  chk_revert_pref: assert property (is_auto && revert && best[1] &&
                    state_reg != rcms_pkg::RCMS_FREE_RUN |=> sel_b_reg == $past(best[0]))
    else $error("revertive mode missed preferred input");
  chk_keep_cur: assert property (is_auto && !revert && cur_ok &&
                    state_reg != rcms_pkg::RCMS_FREE_RUN |=> $stable(sel_b_reg))
    else $error("non-revertive mode switched away");
  chk_pin_select: assert property (sel_mode == rcms_pkg::RCMS_SEL_PIN
                    |=> sel_b_reg == $past(clock_select_pin_sync_reg[1]))
    else $error("pin mode ignored select pin");
  chk_man_hold: assert property (!is_auto && state_reg == rcms_pkg::RCMS_LOCK &&
                    !(man_b ? valid_b : valid_a)
                    |=> state_reg == rcms_pkg::RCMS_HOLDOVER)
    else $error("manual input loss did not hold over");
  chk_flag_irq: assert property (flag_set[0] && !mask_reg[0]
                    |=> flag_reg[0] && interrupt_request_pin_oe_out)
    else $error("los change did not raise interrupt");
  chk_hold_alarm: assert property (hold_enter |=> flag_reg[2] && holdover_out)
    else $error("holdover alarm not set");

  cov_lock: cover property (state_reg == rcms_pkg::RCMS_LOCK);
  cov_hold_back: cover property (state_reg == rcms_pkg::RCMS_HOLDOVER ##1
                    state_reg == rcms_pkg::RCMS_LOCK);
  cov_switch: cover property (state_reg == rcms_pkg::RCMS_LOCK && $changed(sel_b_reg));
  cov_irq: cover property ($rose(interrupt_request_pin_oe_out));
endmodule // rcms_ref_select

// ===== rcms_ref_src.sv
// reference clock sources and select pin driving the clock monitor
`timescale 1ns/10ps
module rcms_ref_src (
  input  wire logic clk_in,    // bench clock
  input  wire logic run_a_in,  // let source a toggle
  input  wire logic run_b_in,  // let source b toggle
  input  wire logic sel_b_in,  // select pin level wanted
  output logic      ref_a_out, // reference a
  output logic      ref_b_out, // reference b
  output logic      clock_select_pin_out   // select pin
);
  // free phase count, one reference period is eight ticks
  logic [2:0] ph_reg = 3'h0; // phase of both sources
  // phase advances every tick, whether or not the sources run
  always @(posedge clk_in) begin
    ph_reg <= ph_reg + 3'h1;
  end
  // a stopped source sits low as its pull-down leaves it
  assign ref_a_out = run_a_in & ph_reg[2];
  // b runs in opposite phase so rising edges never coincide
  assign ref_b_out = run_b_in & ~ph_reg[2];
  // pin low picks a, high picks b
  assign clock_select_pin_out = sel_b_in;
endmodule // rcms_ref_src

// ===== test_rcms_ref_select.sv
// self-checking bench for reference selection and loss monitoring
`timescale 1ns/10ps
`include "rcms_defs.svh"
module test_rcms_ref_select;
  logic        clk_in = 1'b0;   // bench clock
  logic        srst_in = 1'b1;  // sync reset
  logic        mrst_n = 1'b1;   // master reset pin, low
  logic        run_a = 1'b0;    // source a running
  logic        run_b = 1'b0;    // source b running
  logic        clock_select_pin_b = 1'b0;   // select pin wanted
  logic        psel = 1'b0;     // apb select
  logic        penable = 1'b0;  // apb enable
  logic        pwrite = 1'b0;   // apb direction
  logic [7:0]  paddr = 8'h00;   // apb address
  logic [31:0] pwdata = 32'h0;  // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready, pslverr; // apb answer
  logic        lock_out, holdover_out, ref_b_active_out, track_freeze_out;
  logic        hold_gpio_out, irq_o, irq_oe; // holdover pin, interrupt drive
  wire         ref_a, ref_b, clock_select_pin; // partner pins
  wire         los_a_g, los_b_g;   // routed loss pins
  // open drain line with pull-up
  wire         irq_n = irq_oe ? irq_o : 1'b1;
  int          checked = 0;     // comparisons made
  int          miscompares = 0; // mismatches seen
  rcms_ref_src rcms_ref_src_i (.clk_in(clk_in), .run_a_in(run_a), .run_b_in(run_b),
    .sel_b_in(clock_select_pin_b), .ref_a_out(ref_a), .ref_b_out(ref_b), .clock_select_pin_out(clock_select_pin));
  rcms_ref_select rcms_ref_select_i (.clk_in(clk_in), .srst_in(srst_in),
    .master_reset_low_in(mrst_n), .ref_input_a_in(ref_a), .ref_input_b_in(ref_b),
    .clock_select_pin_in(clock_select_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lock_out(lock_out), .holdover_out(holdover_out),
    .ref_b_active_out(ref_b_active_out), .track_freeze_out(track_freeze_out),
    .los_a_gpio_out(los_a_g), .los_b_gpio_out(los_b_g), .hold_gpio_out(hold_gpio_out),
    .interrupt_request_pin_out(irq_o), .interrupt_request_pin_oe_out(irq_oe));
  // 100 mhz bench clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // verdict and end of run
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one comparison, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run
    if (pready !== 1'b1) begin
      chk({31'h0, pready}, 32'h1);
      report_and_stop();
    end
  endtask
  // register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  // register read compared under a mask, with expected error response
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
    chk({31'h0, e}, {31'h0, ex});
  endtask
  // watched outputs: 0 lock, 1 holdover, 2 b active, 3 freeze
  function automatic logic pick(input int w);
    case (w)
      0: pick = lock_out;
      1: pick = holdover_out;
      2: pick = ref_b_active_out;
      default: pick = track_freeze_out;
    endcase
  endfunction
  // bounded wait for a level; running out ends the run
  task wait_on(input int w, input logic v, input int bound);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pick(w) !== v && n < bound);
    chk({31'h0, pick(w)}, {31'h0, v});
    if (pick(w) !== v) report_and_stop();
  endtask
  // level must stand for every one of the cycles
  task hold_on(input int w, input logic v, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk_in);
      if (pick(w) !== v) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(`RCMS_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd(`RCMS_MON_B_ADDR, 32'hFFFFFFFF, 32'h100, 1'b0);
    rd(`RCMS_MASK_ADDR, 32'hFFFFFFFF, 32'h7, 1'b0);
    rd(8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
    wr(`RCMS_MON_A_ADDR, 32'hFFFFFFFF);
    rd(`RCMS_MON_A_ADDR, 32'hFFFFFFFF, 32'h1FFFF, 1'b0);
    // target is period plus two ticks of margin
    wr(`RCMS_MON_A_ADDR, 32'hA);
    wr(`RCMS_MON_B_ADDR, 32'hA);
    hold_on(0, 1'b0, 60);
    rd(`RCMS_STATUS_ADDR, 32'h3, 32'h0, 1'b0);
    $display("test free_run done");
    run_a <= 1'b1;
    wait_on(0, 1'b1, 300);
    chk({31'h0, ref_b_active_out}, 32'h0);
    rd(`RCMS_STATUS_ADDR, 32'h3, 32'h1, 1'b0);
    $display("test lock done");
    wr(`RCMS_CTRL_ADDR, 32'hC);
    run_b <= 1'b1;
    wait_on(2, 1'b1, 300);
    wr(`RCMS_CTRL_ADDR, 32'h0);
    hold_on(2, 1'b1, 100);
    run_b <= 1'b0;
    wait_on(2, 1'b0, 60);
    chk({31'h0, lock_out}, 32'h1);
    $display("test auto_switch done");
    wr(`RCMS_FLAGS_ADDR, 32'h7);
    wr(`RCMS_MASK_ADDR, 32'h0);
    wr(`RCMS_CTRL_ADDR, 32'h70);
    run_a <= 1'b0;
    wait_on(3, 1'b1, 40);
    chk({31'h0, holdover_out}, 32'h0);
    wait_on(1, 1'b1, 40);
    chk({31'h0, hold_gpio_out}, 32'h1);
    chk({31'h0, los_a_g}, 32'h1);
    chk({31'h0, los_b_g}, 32'h1);
    rd(`RCMS_STATUS_ADDR, 32'h83, 32'h82, 1'b0);
    rd(`RCMS_FLAGS_ADDR, 32'h4, 32'h4, 1'b0);
    chk({31'h0, irq_n}, 32'h0);
    wr(`RCMS_FLAGS_ADDR, 32'h7);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq_n}, 32'h1);
    $display("test holdover done");
    run_a <= 1'b1;
    hold_on(0, 1'b0, 40);
    wait_on(0, 1'b1, 300);
    $display("test revalidate done");
    wr(`RCMS_CTRL_ADDR, 32'h2);
    wait_on(1, 1'b1, 20);
    chk({31'h0, ref_b_active_out}, 32'h1);
    wr(`RCMS_CTRL_ADDR, 32'h3);
    wait_on(0, 1'b1, 20);
    chk({31'h0, ref_b_active_out}, 32'h0);
    clock_select_pin_b <= 1'b1;
    wait_on(1, 1'b1, 20);
    chk({31'h0, ref_b_active_out}, 32'h1);
    $display("test manual done");
    mrst_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    mrst_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(`RCMS_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd(`RCMS_MON_A_ADDR, 32'hFFFFFFFF, 32'h100, 1'b0);
    chk({31'h0, lock_out}, 32'h0);
    $display("test master_reset done");
    report_and_stop();
  end
endmodule // test_rcms_ref_select
